// ===== tb_ttr.sv
`timescale 1ns/1ps
module testbench;
	import ttr_pkg::*;

	// ************************************************************
	// Signals and instances.
	// ************************************************************
	localparam int BASE  = 8;     // Short 9-bit run keeps the run brief.
	localparam int LIMIT = 6000;  // Cycle ceiling against a hang.
	logic        clk = 1'h0;      // Core clock.
	logic        rst_b = 1'h0;    // Reset, active low.
	logic [1:0]  reg_ptr;         // Register pointer.
	logic        reg_rd;          // Read strobe.
	logic        reg_wr;          // Write strobe.
	logic [15:0] reg_wdata;       // Write data.
	logic [15:0] reg_rdata;       // Read data.
	logic        reg_rvalid;      // Read data valid.
	logic [15:0] adc = 16'h1AB0;  // Converter word.
	logic        pin_in;          // Pin level seen back.
	logic        th_out;          // Pin drive value.
	logic        th_oe;           // Pin pulled low.
	int          error_cnt = 0;   // Mismatches.
	int          checks_done = 0; // Comparisons.
	int          cyc_cnt = 0;     // Cycles run.

	// The pin is open drain with a pull-up on the board.
	assign pin_in = th_oe ? 1'h0 : 1'h1;

	ttr_top #(.CONV_BASE_CYC(BASE)) u_ttr_top (
		.CLK(clk), .RST_B(rst_b), .REG_PTR(reg_ptr), .REG_RD(reg_rd),
		.REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.REG_RVALID(reg_rvalid), .ADC_SAMPLE(adc), .THERMO_IN(pin_in),
		.THERMO_OUT(th_out), .THERMO_OE(th_oe));

	ttr_host u_ttr_host (
		.clk(clk), .ptr(reg_ptr), .rd(reg_rd), .wr(reg_wr),
		.wdata(reg_wdata), .rdata(reg_rdata), .rvalid(reg_rvalid));

	// Free-running 25 MHz clock.
	always #20 clk = ~clk;

	// ************************************************************
	// Helpers.
	// ************************************************************
	// Counts cycles and cuts a hang short.
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == LIMIT) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: seen %h expected %h",
				$time, seen, exp);
		end
	endtask

	// Waits n edges, then steps just past the edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Holds reset for 20 edges; a mid-run reset uses it too.
	task automatic do_reset();
		rst_b = 1'h0;
		cyc(20);
		rst_b = 1'h1;
	endtask

	task automatic rdchk(input logic [1:0] p, input logic [15:0] e);
		logic [15:0] d;
		logic        ok;
		u_ttr_host.read(p, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(d, e);
	endtask

	// The drive value stays zero; only the enable moves.
	task automatic pin(input logic e);
		chk({14'h0000, th_out, th_oe}, {14'h0000, 1'h0, e});
	endtask

	task automatic wr(input logic [1:0] p, input logic [15:0] d);
		u_ttr_host.write(p, d);
	endtask

	// ************************************************************
	// Scenarios.
	// ************************************************************
	task automatic t_reset();
		rdchk(PTR_CFG, 16'h0000);
		rdchk(PTR_OVER, 16'h5000);
		rdchk(PTR_HYST, 16'h4B00);
		pin(1'h0);
		cyc(BASE * 2);
		rdchk(PTR_TEMP, 16'h1A80);
		$display("test reset done");
	endtask

	task automatic t_regs();
		wr(PTR_OVER, 16'hFFFF);
		rdchk(PTR_OVER, 16'hFFF0);
		wr(PTR_HYST, 16'h8001);
		rdchk(PTR_HYST, 16'h8000);
		wr(PTR_OVER, 16'h5000);
		wr(PTR_HYST, 16'h4B00);
		wr(PTR_CFG, 16'hFFE0);
		rdchk(PTR_CFG, 16'h0060);
		wr(PTR_TEMP, 16'h0000);
		cyc(BASE * 16 + 4);
		rdchk(PTR_TEMP, 16'h1AB0);
		$display("test registers done");
	endtask

	// Negative word at each resolution; the mask grows one bit a step.
	task automatic t_res();
		adc = 16'hE6F0;
		for (int r = 0; r < 4; r++) begin
			wr(PTR_CFG, {9'h000, r[1:0], 5'h00});
			cyc(BASE * 16 + 4);
			rdchk(PTR_TEMP, 16'hE6F0 & ~(16'h007F >> r));
		end
		$display("test resolution done");
	endtask

	// Comparator, four readings; equal values never trip.
	task automatic t_comp();
		// A 12-bit run left from the last test must end before the
		// near-limit word goes in, so that every reading comes at the 9-bit pace.
		wr(PTR_CFG, 16'h0010);
		cyc(BASE * 8 + 4);
		adc = 16'h5010;
		cyc(BASE * 3);
		pin(1'h0);
		adc = 16'h5080;
		cyc(BASE * 3);
		pin(1'h0);
		cyc(12);
		pin(1'h1);
		adc = 16'h4B00;
		cyc(BASE * 3);
		pin(1'h1);
		wr(PTR_CFG, 16'h0011);
		adc = 16'h4B80;
		cyc(BASE + 2);
		adc = 16'h4A80;
		cyc(BASE * 3);
		rdchk(PTR_TEMP, 16'h4B80);
		pin(1'h1);
		wr(PTR_CFG, 16'h0010);
		cyc(BASE + 4);
		pin(1'h0);
		$display("test comparator done");
	endtask

	// Interrupt mode, active high, single reading.
	task automatic t_intr();
		do_reset();
		wr(PTR_CFG, 16'h0006);
		cyc(3);
		pin(1'h1);
		adc = 16'h5080;
		cyc(BASE + 4);
		pin(1'h0);
		rdchk(PTR_HYST, 16'h4B00);
		cyc(2);
		pin(1'h1);
		cyc(BASE * 3);
		pin(1'h1);
		adc = 16'h4A80;
		cyc(BASE + 4);
		pin(1'h0);
		wr(PTR_CFG, 16'h0007);
		cyc(BASE + 4);
		pin(1'h1);
		wr(PTR_CFG, 16'h0006);
		adc = 16'h5080;
		cyc(BASE * 2 + 4);
		pin(1'h0);
		$display("test interrupt done");
	endtask

	// Main sequence.
	initial begin
		do_reset();
		t_reset();
		t_regs();
		t_res();
		t_comp();
		t_intr();
		summarize();
	end
endmodule

// ===== ttr_conv_seq.sv
`timescale 1ns/1ps
module ttr_conv_seq #(
	parameter int BASE_CYC = ttr_pkg::CONV_9B_CYC // Cycles of a 9-bit run.
) (
	input  wire logic        clk,           // Core clock.
	input  wire logic        rst_b,         // Synchronous reset, active low.
	input  wire logic        pd_req,        // Shutdown requested.
	input  wire logic [1:0]  res,           // Resolution code.
	input  wire logic [15:0] sample,        // Converter word.
	output logic             done,          // Result stored, one pulse.
	output logic             standby_entry, // Standby entered, one pulse.
	output logic             standby,       // Standby state.
	output logic [15:0]      result         // Latest stored result.
);
	import ttr_pkg::*;

	// ************************************************************
	// Conversion timer.
	// ************************************************************
	ttr_conv_t          state_q;   // Run or standby.
	logic [CNT_W-1:0]   cnt_q;     // Cycles into the current run.
	logic [1:0]         res_lat_q; // Resolution held for the whole run.
	wire  [CNT_W-1:0]   run_len = CNT_W'(BASE_CYC) << res_lat_q;
	wire                conv_end = (state_q == CONV_RUN) &&
		(cnt_q == run_len - CNT_W'(1));

	assign standby = (state_q == CONV_STANDBY);

	// The resolution is latched at run start so a write mid-run cannot
	// shorten a conversion that is already under way.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q       <= CONV_RUN;
			cnt_q         <= '0;
			res_lat_q     <= 2'h0;
			result        <= 16'h0000;
			done          <= 1'b0;
			standby_entry <= 1'b0;
		end else begin
			done          <= conv_end;
			standby_entry <= conv_end && pd_req;
			case (state_q)
				CONV_RUN: begin
					cnt_q <= conv_end ? '0 : cnt_q + CNT_W'(1);
					if (conv_end) begin
						result    <= sample & ttr_res_mask(res_lat_q);
						res_lat_q <= res;
						if (pd_req) state_q <= CONV_STANDBY;
					end
				end
				CONV_STANDBY: begin
					if (!pd_req) begin
						state_q   <= CONV_RUN;
						res_lat_q <= res;
					end
				end
				default: state_q <= CONV_RUN;
			endcase
		end
	end

endmodule

// ===== ttr_host.sv
`timescale 1ns/1ps
// ************************************************************
// Register master standing in for the serial bus side.
// ************************************************************
module ttr_host (
	input  wire logic        clk,    // Core clock.
	output logic [1:0]       ptr,    // Register pointer.
	output logic             rd,     // Read strobe.
	output logic             wr,     // Write strobe.
	output logic [15:0]      wdata,  // Write data.
	input  wire logic [15:0] rdata,  // Read data.
	input  wire logic        rvalid  // Read data valid.
);
	// Idle levels from time zero, so no strobe leaks into reset.
	initial begin
		ptr   = 2'h0;
		rd    = 1'h0;
		wr    = 1'h0;
		wdata = 16'h0000;
	end

	// One write strobe. Afterwards the lines show the inverse value,
	// so a design that samples them late picks up garbage.
	task automatic write(input logic [1:0] p, input logic [15:0] d);
		@(posedge clk);
		#1;
		ptr   = p;
		wdata = d;
		wr    = 1'h1;
		@(posedge clk);
		#1;
		wr    = 1'h0;
		ptr   = ~p;
		wdata = ~d;
	endtask

	// One read strobe; the answer stands for one cycle only.
	task automatic read(input logic [1:0] p, output logic [15:0] d,
		output logic ok);
		@(posedge clk);
		#1;
		ptr = p;
		rd  = 1'h1;
		@(posedge clk);
		#1;
		rd  = 1'h0;
		ptr = ~p;
		d   = rdata;
		ok  = rvalid;
	endtask
endmodule

// ===== ttr_pkg.sv
package ttr_pkg;

	// ************************************************************
	// Timing constants.
	// ************************************************************
	localparam int CLK_KHZ     = 25000;                // Core clock in kHz.
	localparam int CONV_9B_MS  = 25;                   // Longest 9-bit run, ms.
	localparam int CONV_9B_CYC = CONV_9B_MS * CLK_KHZ; // Same in clock cycles.
	localparam int CNT_W       = 23;                   // Holds 8 x 9-bit run.

	// ************************************************************
	// Register pointers, reset values and field masks.
	// ************************************************************
	localparam logic [1:0]  PTR_TEMP    = 2'h0;     // Conversion result.
	localparam logic [1:0]  PTR_CFG     = 2'h1;     // Configuration byte.
	localparam logic [1:0]  PTR_HYST    = 2'h2;     // Hysteresis limit.
	localparam logic [1:0]  PTR_OVER    = 2'h3;     // Over-temperature limit.
	localparam logic [15:0] OVER_RST    = 16'h5000; // 80 degrees Celsius.
	localparam logic [15:0] HYST_RST    = 16'h4B00; // 75 degrees Celsius.
	localparam logic [15:0] DATA_MASK   = 16'hFFF0; // Bits 3..0 are zero.
	localparam logic [15:0] RES9_MASK   = 16'hFF80; // Nine data bits kept.
	localparam logic [7:0]  CFG_RST     = 8'h00;    // Power-up configuration.
	localparam logic [7:0]  CFG_WR_MASK = 8'h7F;    // Top bit reads as zero.
	localparam logic        MODE_CMP    = 1'b0;     // Comparator mode code.

	// ************************************************************
	// Types.
	// ************************************************************
	typedef struct packed {
		logic reserved;               // Always zero.
		logic resolution_select_hi;   // Resolution code, upper bit.
		logic resolution_select_lo;   // Resolution code, lower bit.
		logic fault_count_select_hi;  // Fault count code, upper bit.
		logic fault_count_select_lo;  // Fault count code, lower bit.
		logic output_polarity;        // One makes the active level high.
		logic thermostat_mode_select; // One selects interrupt mode.
		logic power_down_select;      // One requests shutdown.
	} ttr_cfg_t;

	typedef enum logic [1:0] {
		CONV_RUN     = 2'b01,         // Converting.
		CONV_STANDBY = 2'b10          // Low-power standby.
	} ttr_conv_t;

	// ************************************************************
	// Shared decoders.
	// ************************************************************
	// Keeps the 9 + res most significant bits.
	function automatic logic [15:0] ttr_res_mask(input logic [1:0] res);
		ttr_res_mask = 16'($signed(RES9_MASK) >>> res);
	endfunction

	// Number of consecutive readings that trigger the output.
	function automatic logic [2:0] ttr_fault_target(input logic [1:0] code);
		case (code)
			2'h0: ttr_fault_target = 3'h1;
			2'h1: ttr_fault_target = 3'h2;
			2'h2: ttr_fault_target = 3'h4;
			default: ttr_fault_target = 3'h6;
		endcase
	endfunction

	// Signed strict compare, both sides cut to the resolution.
	function automatic logic ttr_above(input logic [15:0] a,
		input logic [15:0] b, input logic [1:0] res);
		ttr_above = $signed(a & ttr_res_mask(res)) >
			$signed(b & ttr_res_mask(res));
	endfunction

endpackage

// ===== ttr_thermo.sv
`timescale 1ns/1ps
module ttr_thermo (
	input  wire logic          clk,      // Core clock.
	input  wire logic          rst_b,    // Synchronous reset, active low.
	input  wire logic          done,     // New result stored.
	input  wire logic [15:0]   result,   // Latest result.
	input  wire logic [15:0]   over_lim, // Over-temperature limit.
	input  wire logic [15:0]   hyst_lim, // Hysteresis limit.
	input  wire ttr_pkg::ttr_cfg_t cfg,  // Configuration.
	input  wire logic          pd_entry, // Standby entered.
	input  wire logic          rd_clear, // Any register read.
	output logic               active    // Output asserted.
);
	import ttr_pkg::*;

	// ************************************************************
	// Trigger decision.
	// ************************************************************
	logic       seek_hyst_q; // Interrupt mode waits for a low event.
	logic [2:0] cnt_q;       // Consecutive matching readings.
	wire  [1:0] res  = {cfg.resolution_select_hi, cfg.resolution_select_lo};
	wire  [1:0] fcod = {cfg.fault_count_select_hi, cfg.fault_count_select_lo};
	wire  cmp_mode = (cfg.thermostat_mode_select == MODE_CMP);
	wire  above = ttr_above(result, over_lim, res);
	wire  below = ttr_above(hyst_lim, result, res);
	wire  want_low = cmp_mode ? active : seek_hyst_q;
	wire  cond = want_low ? below : above;
	// Comparator release needs a single low reading.
	wire  [2:0] target = (cmp_mode && active) ? 3'h1 : ttr_fault_target(fcod);
	// Interrupt mode does not count while an event is still pending.
	wire  armed = cmp_mode || !active;
	wire  hit   = done && cond && armed;
	wire  reach = hit && (cnt_q + 3'h1 >= target);
	wire  clear = !cmp_mode && (rd_clear || pd_entry);

	// A trigger in the same cycle as a read clear wins, so no event is lost.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			active      <= 1'b0;
			seek_hyst_q <= 1'b0;
			cnt_q       <= 3'h0;
		end else if (reach) begin
			active      <= cmp_mode ? !active : 1'b1;
			seek_hyst_q <= cmp_mode ? seek_hyst_q : !seek_hyst_q;
			cnt_q       <= 3'h0;
		end else begin
			if (clear) active <= 1'b0;
			if (done) cnt_q <= hit ? cnt_q + 3'h1 : 3'h0;
		end
	end

endmodule

// ===== ttr_top.sv
`timescale 1ns/1ps
module ttr_top #(
	parameter int CONV_BASE_CYC = ttr_pkg::CONV_9B_CYC // 9-bit run cycles.
) (
	input  wire logic        CLK,          // Core clock, 25 MHz.
	input  wire logic        RST_B,        // Synchronous reset, active low.
	input  wire logic [1:0]  REG_PTR,      // Register pointer.
	input  wire logic        REG_RD,       // Read strobe, one cycle.
	input  wire logic        REG_WR,       // Write strobe, one cycle.
	input  wire logic [15:0] REG_WDATA,    // Write data.
	output logic [15:0]      REG_RDATA,    // Read data, registered.
	output logic             REG_RVALID,   // Read data valid, one cycle.
	input  wire logic [15:0] ADC_SAMPLE,   // Converter word, same clock.
	input  wire logic        THERMO_IN,    // Output pin level, unused.
	output logic             THERMO_OUT,   // Output pin drive value.
	output logic             THERMO_OE     // High while pin pulled low.
);
	import ttr_pkg::*;

	// ************************************************************
	// Register file.
	// ************************************************************
	ttr_cfg_t    cfg_q;  // Configuration register.
	logic [15:0] over_q; // Over-temperature limit.
	logic [15:0] hyst_q; // Hysteresis limit.

	// Results and thermostat state from the two engines.
	logic        conv_done;     // Result stored this cycle.
	logic        pd_entry;      // Standby entered this cycle.
	logic        in_standby;    // Converter resting.
	logic [15:0] conv_result;   // Latest stored result.
	logic        thermo_active; // Logical output state.

	// Field views of the configuration.
	wire [1:0] res_code = {cfg_q.resolution_select_hi,
		cfg_q.resolution_select_lo};
	wire [1:0] fault_code = {cfg_q.fault_count_select_hi,
		cfg_q.fault_count_select_lo};
	wire       cmp_mode = (cfg_q.thermostat_mode_select == MODE_CMP);

	// Write decode, one select per writable register.
	wire wr_cfg  = REG_WR && (REG_PTR == PTR_CFG);
	wire wr_over = REG_WR && (REG_PTR == PTR_OVER);
	wire wr_hyst = REG_WR && (REG_PTR == PTR_HYST);

	// Read selection. The configuration sits in the low byte and its
	// reserved top bit is never stored, so it always reads zero.
	logic [15:0] rd_mux;
	assign rd_mux = (REG_PTR == PTR_TEMP) ? conv_result :
		(REG_PTR == PTR_CFG) ? {8'h00, cfg_q} :
		(REG_PTR == PTR_HYST) ? hyst_q : over_q;

	// Configuration and limits. Writes to the result pointer are dropped,
	// since that register belongs to the converter alone.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			cfg_q  <= ttr_cfg_t'(CFG_RST);
			over_q <= OVER_RST;
			hyst_q <= HYST_RST;
		end else begin
			if (wr_cfg) cfg_q <= ttr_cfg_t'(REG_WDATA[7:0] & CFG_WR_MASK);
			if (wr_over) over_q <= REG_WDATA & DATA_MASK;
			if (wr_hyst) hyst_q <= REG_WDATA & DATA_MASK;
		end
	end

	// Read port. Data is taken one edge after the strobe, which keeps the
	// result mux off the output pins and lets a read never stall anything.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			REG_RDATA  <= 16'h0000;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RVALID <= REG_RD;
			if (REG_RD) REG_RDATA <= rd_mux;
		end
	end

	// ************************************************************
	// Engines.
	// ************************************************************
	// Conversion pacing, shutdown sequencing and result capture.
	ttr_conv_seq #(
		.BASE_CYC      (CONV_BASE_CYC)
	) u_conv (
		.clk           (CLK),
		.rst_b         (RST_B),
		.pd_req        (cfg_q.power_down_select),
		.res           (res_code),
		.sample        (ADC_SAMPLE),
		.done          (conv_done),
		.standby_entry (pd_entry),
		.standby       (in_standby),
		.result        (conv_result)
	);

	// Limit compare and fault filtering.
	ttr_thermo u_thermo (
		.clk      (CLK),
		.rst_b    (RST_B),
		.done     (conv_done),
		.result   (conv_result),
		.over_lim (over_q),
		.hyst_lim (hyst_q),
		.cfg      (cfg_q),
		.pd_entry (pd_entry),
		.rd_clear (REG_RD),
		.active   (thermo_active)
	);

	// ************************************************************
	// Open-drain output pin.
	// ************************************************************
	// The pin is only ever pulled low. With the default polarity the
	// asserted state pulls low; with polarity one the idle state does.
	// The drive value is a constant flop so the pin stays glitch free.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			THERMO_OUT <= 1'b0;
			THERMO_OE  <= 1'b0;
		end else begin
			THERMO_OUT <= 1'b0;
			THERMO_OE  <= thermo_active ^ cfg_q.output_polarity;
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	// Converter must run straight out of reset.
	property p_run_at_reset;
		@(posedge CLK) $rose(RST_B) |-> !in_standby && res_code == 2'h0;
	endproperty
	a_run_at_reset: assert property (p_run_at_reset)
		else $error("converter not running after reset");

	// A result read returns the word stored before the strobe.
	property p_read_result;
		@(posedge CLK) disable iff (!RST_B)
		REG_RD && REG_PTR == PTR_TEMP |=>
			REG_RVALID && REG_RDATA == $past(conv_result);
	endproperty
	a_read_result: assert property (p_read_result)
		else $error("result read returned wrong word");

	// Stored results never carry bits beyond twelve.
	property p_low_nibble;
		@(posedge CLK) disable iff (!RST_B)
		conv_done |-> conv_result[3:0] == 4'h0 && over_q[3:0] == 4'h0 &&
			hyst_q[3:0] == 4'h0;
	endproperty
	a_low_nibble: assert property (p_low_nibble)
		else $error("low nibble not zero");

	// Over-temperature limit writes are kept, low nibble forced to zero.
	property p_limit_hold;
		@(posedge CLK) disable iff (!RST_B)
		wr_over |=> over_q == ($past(REG_WDATA) & DATA_MASK);
	endproperty
	a_limit_hold: assert property (p_limit_hold)
		else $error("limit write not kept");

	// Shutdown only after the running conversion has been stored.
	property p_pd_after_done;
		@(posedge CLK) disable iff (!RST_B)
		$rose(in_standby) |-> conv_done && $past(cfg_q.power_down_select);
	endproperty
	a_pd_after_done: assert property (p_pd_after_done)
		else $error("standby without a finished conversion");

	// Comparator output is frozen through standby.
	property p_cmp_hold;
		@(posedge CLK) disable iff (!RST_B)
		in_standby && !conv_done && cmp_mode |=>
			thermo_active == $past(thermo_active);
	endproperty
	a_cmp_hold: assert property (p_cmp_hold)
		else $error("comparator output moved in standby");

	// Interrupt output drops one edge after a read when nothing sets it.
	property p_int_read_clear;
		@(posedge CLK) disable iff (!RST_B)
		!cmp_mode && REG_RD && !conv_done ##1 !conv_done |-> !thermo_active;
	endproperty
	a_int_read_clear: assert property (p_int_read_clear)
		else $error("interrupt output not cleared by read");

	// Single fault count: one reading over the limit sets the output.
	property p_cmp_set;
		@(posedge CLK) disable iff (!RST_B)
		cmp_mode && conv_done && !thermo_active && fault_code == 2'h0 &&
			ttr_above(conv_result, over_q, res_code) |=> thermo_active;
	endproperty
	a_cmp_set: assert property (p_cmp_set)
		else $error("comparator did not assert over limit");

	// Comparator releases on the first reading below hysteresis.
	property p_cmp_release;
		@(posedge CLK) disable iff (!RST_B)
		cmp_mode && conv_done && thermo_active &&
			ttr_above(hyst_q, conv_result, res_code) |=> !thermo_active;
	endproperty
	a_cmp_release: assert property (p_cmp_release)
		else $error("comparator did not release");

	// A reading equal to the limit does not count as exceeding it.
	property p_strict;
		@(posedge CLK) disable iff (!RST_B)
		cmp_mode && conv_done && !thermo_active &&
			(conv_result & ttr_res_mask(res_code)) ==
			(over_q & ttr_res_mask(res_code)) |=> !thermo_active;
	endproperty
	a_strict: assert property (p_strict)
		else $error("equal reading treated as over limit");

	// The pin enable follows output state and polarity one edge later.
	property p_pin_level;
		@(posedge CLK) disable iff (!RST_B)
		$changed(thermo_active) |=>
			THERMO_OE == ($past(thermo_active) ^
			$past(cfg_q.output_polarity));
	endproperty
	a_pin_level: assert property (p_pin_level)
		else $error("pin enable does not match polarity");

	// No trigger while the fault count has not been reached.
	property p_fault_wait;
		@(posedge CLK) disable iff (!RST_B)
		conv_done && cmp_mode && !thermo_active && fault_code == 2'h3 &&
			!ttr_above(conv_result, over_q, res_code) ##1
			(!conv_done)[*3] |-> !thermo_active;
	endproperty
	a_fault_wait: assert property (p_fault_wait)
		else $error("output set before fault count reached");

	// ************************************************************
	// Checks on the bus, standby and output hold.
	// ************************************************************
	// These guard the quiet paths that a short test seldom walks, such
	// as a read landing while the converter rests.

	// Hysteresis writes are kept, low nibble forced to zero.
	property p_hyst_hold;
		@(posedge CLK) disable iff (!RST_B)
		wr_hyst |=> hyst_q == ($past(REG_WDATA) & DATA_MASK);
	endproperty
	a_hyst_hold: assert property (p_hyst_hold)
		else $error("hysteresis write not kept");

	// Configuration writes land, with the reserved bit dropped.
	property p_cfg_write;
		@(posedge CLK) disable iff (!RST_B)
		wr_cfg |=> cfg_q == ttr_cfg_t'($past(REG_WDATA[7:0]) & CFG_WR_MASK);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("configuration write not kept");

	// Every read strobe is answered on the next edge.
	property p_rvalid_pulse;
		@(posedge CLK) disable iff (!RST_B)
		REG_RD |=> REG_RVALID;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse)
		else $error("read not answered");

	// No answer appears without a read strobe.
	property p_rvalid_idle;
		@(posedge CLK) disable iff (!RST_B)
		!REG_RD |=> !REG_RVALID;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle)
		else $error("read answer without a strobe");

	// Once resting, the converter stores nothing more.
	property p_standby_quiet;
		@(posedge CLK) disable iff (!RST_B)
		in_standby && $past(in_standby) |-> !conv_done;
	endproperty
	a_standby_quiet: assert property (p_standby_quiet)
		else $error("result stored during standby");

	// Clearing the shutdown bit restarts conversions at once.
	property p_resume;
		@(posedge CLK) disable iff (!RST_B)
		in_standby && !cfg_q.power_down_select |=> !in_standby;
	endproperty
	a_resume: assert property (p_resume)
		else $error("converter did not resume");

	// Entering standby drops a pending interrupt output.
	property p_int_pd_clear;
		@(posedge CLK) disable iff (!RST_B)
		!cmp_mode && pd_entry && thermo_active |=> !thermo_active;
	endproperty
	a_int_pd_clear: assert property (p_int_pd_clear)
		else $error("interrupt output kept through shutdown");

	// A read never releases the comparator output.
	property p_cmp_no_clear;
		@(posedge CLK) disable iff (!RST_B)
		cmp_mode && REG_RD && thermo_active && !conv_done |=> thermo_active;
	endproperty
	a_cmp_no_clear: assert property (p_cmp_no_clear)
		else $error("comparator output cleared by a read");

	// An interrupt output holds until a read or shutdown.
	property p_int_hold;
		@(posedge CLK) disable iff (!RST_B)
		!cmp_mode && thermo_active && !REG_RD && !pd_entry |=> thermo_active;
	endproperty
	a_int_hold: assert property (p_int_hold)
		else $error("interrupt output dropped on its own");

	// Reset leaves the pin released and the bus quiet.
	property p_reset_idle;
		@(posedge CLK)
		!RST_B |=> !THERMO_OE && !REG_RVALID && !thermo_active;
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");

endmodule
